// File: rtl/sep_pkg.sv
/*
  constants for the mfm read data separator gating block.
  assumes a 50 mhz ref_clk; all cycle counts derive from nanosecond figures.
*/
package sep_pkg;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned DRIVE_COUNT = 4;
  localparam int unsigned PULSE_NS = 50;
  localparam int unsigned PULSE_CYC =
    (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RCLK_NS = 200;
  // timeout 1.25 rclk periods, a longest time: round down
  localparam int unsigned TIMEOUT_NS = (RCLK_NS * 5) / 4;
  localparam int unsigned TIMEOUT_CYC =
    (TIMEOUT_NS / CLK_PERIOD_NS) < 1 ? 1 : TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int unsigned RUN_LENGTH = 16;
  localparam int unsigned WINDOW_NS = 50;
  localparam int unsigned WINDOW_CYC =
    (WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DELAY_NS = 60;
  localparam int unsigned DELAY_CYC =
    (DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] DIV_RESET = 2'h0;
  localparam logic [4:0] RUN_RESET = 5'h00;
endpackage

// File: rtl/pulse_if.sv
/*
  interface carrying raw bit events from the buffer to the one-shot that reshapes them.
  assumes one clock domain shared by both ends.
*/
`timescale 1ns/1ns
interface pulse_if;
  logic valid;
  logic ready;
  logic [1:0] drive;
  modport src (output valid, output drive, input ready);
  modport dst (input valid, input drive, output ready);
endinterface

// File: rtl/pulse_buffer.sv
/*
  two-entry buffer holding the drive tag of each raw bit rising edge event.
  assumes the sink may stall; in_ready goes low when both entries fill.
*/
`timescale 1ns/1ns
module pulse_buffer #(
  parameter int unsigned WIDTH = 2,
  parameter int unsigned DEPTH = 2
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  pulse_if.src out
);
  if (DEPTH != 2 || WIDTH != 2) begin : bad_shape
    $error("pulse_buffer supports only width 2, depth 2");
  end
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic [1:0] count_reg;
  logic push;
  logic pop;
  assign in_ready = (count_reg != 2'h2);
  assign out.valid = (count_reg != 2'h0);
  assign out.drive = mem_reg[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out.valid && out.ready;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_reg[0] <= '0;
      mem_reg[1] <= '0;
    end else if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// File: rtl/read_gating.sv
/*
  mfm read front end: drive select, pulse reshaping, reference clocks,
  run detector with data-run latch, and the digital phase detector.
  assumes raw data and vco edge inputs are synchronous to ref_clk.
*/
// Notes on behaviour
// RULE1: pass only the selected drive's raw data, from up to four drives.
// RULE2: reshape each raw bit into a fixed active-high pulse of 50 ns; the code gives 3 ref_clk cycles, 60 ns.
// RULE3: divide the 4x clock into a 2x reference and a 1x write clock.
// RULE4: the oscillator free-runs at twice the recovered clock rate.
// RULE5: with no read in progress, feed the detector from the reference.
// RULE6: switch to live data only after 16 evenly spaced bits.
// RULE7: bits count as consecutive only when spaced under 1.25 periods.
// RULE8: each bit arriving before timeout advances the run counter.
// RULE9: a missed timeout clears the run counter to zero.
// RULE10: terminal count sets the latch driving data_run_flag_n low.
// RULE11: data_run_flag_n is readable by the controlling processor.
// RULE12: window opens on each data bit, closes on delay or oscillator edge.
// RULE13: after both edges arrive, detector stays reset until next bit.
// RULE14: delayed bit sets pump up; oscillator edge sets pump down.
// RULE15: in phase, both pumps assert and release together; the code keeps pump_up and pump_down both low.
// RULE16: dropping the read gate clears latch and counter.
`timescale 1ns/1ns
module read_gating #(
  parameter int unsigned DRIVES = sep_pkg::DRIVE_COUNT
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [DRIVES-1:0] raw_data,
  input wire logic [1:0] drive_sel,
  input wire logic read_gate,
  input wire logic vco_output_edge_n,
  output logic shaped_pulse,
  output logic double_rate_reference,
  output logic write_clock,
  output logic detector_input,
  output logic data_run_flag_n,
  output logic pump_up,
  output logic pump_down,
  output logic window_open
);
  if (DRIVES < 1 || DRIVES > 4) begin : bad_drives
    $error("read_gating supports one to four drives");
  end

  // drive select and leading edge of the selected raw bit
  logic sel_raw;
  logic sel_raw_reg;
  logic raw_rise;
  always_comb begin
    sel_raw = 1'b0;
    for (int i = 0; i < DRIVES; i++) begin
      if (drive_sel == 2'(i)) begin
        sel_raw = raw_data[i]; // RULE1
      end
    end
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sel_raw_reg <= 1'b0;
    end else begin
      sel_raw_reg <= sel_raw;
    end
  end
  assign raw_rise = sel_raw && !sel_raw_reg;

  // event buffer: a held pulse stalls nothing upstream, events queue
  logic buf_ready;
  pulse_if pif ();
  pulse_buffer #(.WIDTH(2), .DEPTH(2)) u_buf (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .in_valid(raw_rise),
    .in_ready(buf_ready),
    .in_data(drive_sel),
    .out(pif)
  );

  // one-shot: fixed width pulse regardless of drive pulse width
  logic [3:0] shot_reg;
  logic bit_event;
  assign pif.ready = (shot_reg == 4'h0);
  assign bit_event = pif.valid && pif.ready;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      shot_reg <= 4'h0;
    end else if (bit_event) begin
      shot_reg <= 4'(sep_pkg::PULSE_CYC); // RULE2
    end else if (shot_reg != 4'h0) begin
      shot_reg <= shot_reg - 4'h1;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      shaped_pulse <= 1'b0;
    end else begin
      shaped_pulse <= bit_event || (shot_reg > 4'h1); // RULE2
    end
  end

  // ref_clk stands in for the 4x crystal; divide to 2x and 1x
  logic [1:0] div_reg;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_reg <= sep_pkg::DIV_RESET;
    end else begin
      div_reg <= div_reg + 2'h1; // RULE3
    end
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      double_rate_reference <= 1'b0;
      write_clock <= 1'b0;
    end else begin
      // inverted so the reference rises on the first edge after reset
      double_rate_reference <= ~div_reg[0]; // RULE3 RULE4
      write_clock <= div_reg[1]; // RULE3
    end
  end

  // run detector: retriggerable timeout and counter
  logic [7:0] timeout_reg;
  logic [4:0] run_reg;
  logic run_latch_reg;
  logic timed_out;
  assign timed_out = (timeout_reg == 8'h00);
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      timeout_reg <= 8'h00;
    end else if (!read_gate) begin
      timeout_reg <= 8'h00;
    end else if (bit_event) begin
      timeout_reg <= 8'(sep_pkg::TIMEOUT_CYC); // RULE7
    end else if (!timed_out) begin
      timeout_reg <= timeout_reg - 8'h01;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      run_reg <= sep_pkg::RUN_RESET;
    end else if (!read_gate) begin
      run_reg <= sep_pkg::RUN_RESET; // RULE16
    end else if (bit_event && !timed_out) begin
      if (run_reg != 5'(sep_pkg::RUN_LENGTH)) begin
        run_reg <= run_reg + 5'h01; // RULE8
      end
    end else if (timed_out) begin
      run_reg <= sep_pkg::RUN_RESET; // RULE9
    end
  end
  // the first bit only starts the timeout, so 16 retriggers are needed
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      run_latch_reg <= 1'b0;
    end else if (!read_gate) begin
      run_latch_reg <= 1'b0; // RULE16
    end else if (run_reg == 5'(sep_pkg::RUN_LENGTH)) begin
      run_latch_reg <= 1'b1; // RULE10 RULE6
    end
  end
  assign data_run_flag_n = !run_latch_reg; // RULE11

  // source select for the phase detector
  logic det_src;
  logic det_src_reg;
  logic det_rise;
  // reference kept on until the latch sets, so no harmonic lock
  assign det_src = run_latch_reg ? shaped_pulse
                                 : double_rate_reference; // RULE5 RULE6
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      detector_input <= 1'b0;
      det_src_reg <= 1'b0;
    end else begin
      detector_input <= det_src;
      det_src_reg <= detector_input;
    end
  end
  assign det_rise = detector_input && !det_src_reg;

  // phase detector: delayed bit sets up, vco edge sets down
  logic [2:0] delay_reg;
  logic [2:0] win_reg;
  logic vco_n_reg;
  logic vco_edge;
  logic delayed_bit;
  logic up_reg;
  logic down_reg;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      vco_n_reg <= 1'b1;
    end else begin
      vco_n_reg <= vco_output_edge_n;
    end
  end
  assign vco_edge = vco_n_reg && !vco_output_edge_n;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      delay_reg <= 3'h0;
    end else if (det_rise) begin
      delay_reg <= 3'(sep_pkg::DELAY_CYC); // RULE12
    end else if (delay_reg != 3'h0) begin
      delay_reg <= delay_reg - 3'h1;
    end
  end
  assign delayed_bit = (delay_reg == 3'h1);
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      win_reg <= 3'h0;
    end else if (det_rise) begin
      win_reg <= 3'(sep_pkg::WINDOW_CYC); // RULE12
    end else if (vco_edge || delayed_bit) begin
      win_reg <= 3'h0; // RULE12
    end else if (win_reg != 3'h0) begin
      win_reg <= win_reg - 3'h1;
    end
  end
  assign window_open = (win_reg != 3'h0);
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      up_reg <= 1'b0;
      down_reg <= 1'b0;
    end else if (det_rise || (up_reg && down_reg)) begin
      up_reg <= 1'b0; // RULE13 RULE15
      down_reg <= 1'b0;
    end else begin
      if (delayed_bit) begin
        up_reg <= 1'b1; // RULE14
      end
      if (vco_edge && (window_open || up_reg)) begin
        down_reg <= 1'b1; // RULE14
      end
    end
  end
  assign pump_up = up_reg && !down_reg;
  assign pump_down = down_reg && !up_reg;

  property p_gate_clear;
    @(posedge ref_clk) disable iff (!rst_b)
      !read_gate |=> data_run_flag_n && (run_reg == 5'h00);
  endproperty
  a_gate_clear: assert property (p_gate_clear) // RULE16
    else $error("read gate low did not clear run state");

  property p_flag_src;
    @(posedge ref_clk) disable iff (!rst_b)
      data_run_flag_n |->
        ##1 (detector_input == $past(double_rate_reference));
  endproperty
  a_flag_src: assert property (p_flag_src) // RULE5
    else $error("reference not fed while no data run");

  property p_run_set;
    @(posedge ref_clk) disable iff (!rst_b)
      read_gate && (run_reg == 5'h10) |=> !data_run_flag_n;
  endproperty
  a_run_set: assert property (p_run_set) // RULE10
    else $error("terminal count did not set data run");

  property p_no_early;
    @(posedge ref_clk) disable iff (!rst_b)
      $fell(data_run_flag_n) |-> $past(run_reg) == 5'h10;
  endproperty
  a_no_early: assert property (p_no_early) // RULE6
    else $error("data run set before sixteen bits");

  property p_timeout_clear;
    @(posedge ref_clk) disable iff (!rst_b)
      read_gate && timed_out && !bit_event |=> run_reg == 5'h00;
  endproperty
  a_timeout_clear: assert property (p_timeout_clear) // RULE9
    else $error("timeout did not clear run counter");

  property p_advance;
    @(posedge ref_clk) disable iff (!rst_b)
      read_gate && bit_event && !timed_out && (run_reg < 5'h10)
        |=> run_reg == $past(run_reg) + 5'h01;
  endproperty
  a_advance: assert property (p_advance) // RULE8
    else $error("run counter did not advance");

  property p_shot_width;
    @(posedge ref_clk) disable iff (!rst_b)
      bit_event |=> shaped_pulse [*3] ##1 !shaped_pulse;
  endproperty
  a_shot_width: assert property (p_shot_width) // RULE2
    else $error("shaped pulse width wrong");

  property p_ref_div;
    @(posedge ref_clk) disable iff (!rst_b)
      $past(rst_b) |->
        double_rate_reference != $past(double_rate_reference);
  endproperty
  a_ref_div: assert property (p_ref_div) // RULE3
    else $error("reference clock not toggling each cycle");

  property p_pump_excl;
    @(posedge ref_clk) disable iff (!rst_b)
      !(pump_up && pump_down);
  endproperty
  a_pump_excl: assert property (p_pump_excl) // RULE15
    else $error("net pump both ways");

  property p_both_reset;
    @(posedge ref_clk) disable iff (!rst_b)
      up_reg && down_reg |=> !up_reg && !down_reg;
  endproperty
  a_both_reset: assert property (p_both_reset) // RULE13
    else $error("detector not reset after both edges");

  c_run: cover property (@(posedge ref_clk) disable iff (!rst_b)
    $fell(data_run_flag_n));
  c_timeout: cover property (@(posedge ref_clk) disable iff (!rst_b)
    read_gate && timed_out && (run_reg != 5'h00));
  c_pump_up: cover property (@(posedge ref_clk) disable iff (!rst_b)
    pump_up);
  c_pump_down: cover property (@(posedge ref_clk) disable iff (!rst_b)
    pump_down);
  c_full: cover property (@(posedge ref_clk) disable iff (!rst_b)
    !buf_ready);
endmodule

// File: verif/drive_model.sv
/*
  model of the drives' serial read data lines.
  assumes the bench calls send at a rising edge of ref_clk.
*/
`timescale 1ns/1ns
module drive_model (
  input wire logic ref_clk,
  input wire logic [1:0] sel,
  input wire logic noise_on,
  output logic [3:0] raw_data
);
  logic [3:0] noise_reg = 4'h0;
  logic bit_reg = 1'b0;
  // unselected drives chatter so that a leak shows up
  always @(posedge ref_clk) begin
    noise_reg <= noise_reg + 4'h1;
  end
  always_comb begin
    raw_data = noise_on ? noise_reg : 4'h0;
    raw_data[sel] = bit_reg;
  end
  // drives differ in pulse width, so width is random
  task automatic send(input int n, input int gap);
    int w;
    for (int i = 0; i < n; i++) begin
      w = 1 + ($urandom % 3);
      // a low cycle is needed between bits or the next rise is lost
      if (w >= gap) begin
        w = gap - 1;
      end
      bit_reg <= 1'b1;
      repeat (w) @(posedge ref_clk);
      bit_reg <= 1'b0;
      repeat (gap - w) @(posedge ref_clk);
    end
  endtask
endmodule

// File: verif/read_gating_tb_top.sv
/*
  self-checking bench for the read gating front end.
  assumes drive_model on raw_data; the bench plays the oscillator.
*/
`timescale 1ns/1ns
module read_gating_tb_top;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [1:0] drive_sel = 2'h0;
  logic read_gate = 1'b0;
  logic vco_n = 1'b1;
  logic noise_on = 1'b0;
  logic [3:0] raw_data;
  logic shaped_pulse, drr, write_clock, det, flag_n, pump_up, pump_down;
  logic window_open, sp_q, drr_q, wc_q, det_q, exp_flag;
  int n_fail = 0;
  int checks_done = 0;
  int n_sp, n_hi, n_up, n_dn, n_win, n_same, n_wc, n_det, bits, gap;

  always #10 ref_clk = ~ref_clk;

  drive_model i_drive_model (
    .ref_clk(ref_clk),
    .sel(drive_sel),
    .noise_on(noise_on),
    .raw_data(raw_data)
  );

  read_gating i_read_gating (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .raw_data(raw_data),
    .drive_sel(drive_sel),
    .read_gate(read_gate),
    .vco_output_edge_n(vco_n),
    .shaped_pulse(shaped_pulse),
    .double_rate_reference(drr),
    .write_clock(write_clock),
    .detector_input(det),
    .data_run_flag_n(flag_n),
    .pump_up(pump_up),
    .pump_down(pump_down),
    .window_open(window_open)
  );

  // counted on the falling edge, where outputs are settled
  always @(negedge ref_clk) begin
    n_sp += int'(shaped_pulse & !sp_q);
    n_hi += int'(shaped_pulse);
    n_up += int'(pump_up);
    n_dn += int'(pump_down);
    n_win += int'(window_open);
    n_same += int'(drr === drr_q);
    n_wc += int'(write_clock & !wc_q);
    n_det += int'(det !== det_q);
    sp_q = shaped_pulse;
    drr_q = drr;
    wc_q = write_clock;
    det_q = det;
  end

  task automatic clr;
    @(posedge ref_clk);
    {n_sp, n_hi, n_up, n_dn, n_win, n_same, n_wc, n_det} = '0;
  endtask

  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %0d seen %0d", name, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // a run locks only if spaced under the timeout and long enough
  function automatic logic flag_exp(input int b, input int g);
    return (g <= sep_pkg::TIMEOUT_CYC && b > sep_pkg::RUN_LENGTH)
      ? 1'b0 : 1'b1;
  endfunction

  task automatic run(input int b, input int g);
    i_drive_model.send(b, g);
    repeat (4) @(posedge ref_clk);
    exp_flag = exp_flag & flag_exp(b, g);
    chk("run_flag", flag_n, exp_flag);
  endtask

  initial begin
    void'($urandom(51));
    exp_flag = 1'b1;
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    clr();
    // one extra cycle: detector_input lags the reference by one
    repeat (41) @(posedge ref_clk);
    chk("ref_same", n_same, 0);
    chk("wclk_rises", n_wc, 10);
    chk("det_toggles", n_det, 40);
    chk("flag_idle", flag_n, 1);
    noise_on <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      drive_sel <= s[1:0];
      clr();
      i_drive_model.send(2, 20);
      repeat (10) @(posedge ref_clk);
      chk("pulses", n_sp, 2);
      chk("pulse_hi", n_hi, 2 * sep_pkg::PULSE_CYC);
    end
    // two rises close together must both get through the buffer
    clr();
    i_drive_model.send(2, 2);
    repeat (20) @(posedge ref_clk);
    chk("burst", n_sp, 2);
    drive_sel <= 2'($urandom % 4);
    read_gate <= 1'b1;
    i_drive_model.send(10, 10);
    repeat (10) @(posedge ref_clk);
    run(10, 10);
    run(sep_pkg::RUN_LENGTH, 10);
    run(sep_pkg::RUN_LENGTH + 1, 15);
    run(sep_pkg::RUN_LENGTH + 1, sep_pkg::TIMEOUT_CYC + 1);
    for (int k = 0; k < 6; k++) begin
      bits = 2 + ($urandom % 20);
      gap = 10 + 5 * ($urandom % 3);
      run(bits, gap);
    end
    run(sep_pkg::RUN_LENGTH + 1, 10);
    read_gate <= 1'b0;
    exp_flag = 1'b1;
    repeat (3) @(posedge ref_clk);
    chk("flag_drop", flag_n, 1);
    read_gate <= 1'b1;
    run(sep_pkg::RUN_LENGTH + 1, 10);
    clr();
    i_drive_model.send(3, 10);
    chk("det_data", n_det, 6);
    clr();
    fork
      i_drive_model.send(1, 20);
      begin
        for (int i = 0; i < 10 && window_open !== 1'b1; i++) begin
          @(posedge ref_clk);
        end
        vco_n <= 1'b0;
        @(posedge ref_clk);
        vco_n <= 1'b1;
      end
    join
    chk("window", n_win > 0, 1);
    chk("down_seen", n_dn > 0, 1);
    clr();
    repeat (10) @(posedge ref_clk);
    chk("pumps_idle", n_up + n_dn, 0);
    clr();
    i_drive_model.send(1, 20);
    chk("up_seen", n_up > 0, 1);
    chk("no_down", n_dn, 0);
    test_done();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    test_done();
  end
endmodule
